//--- hw/spsp_consts.svh
// Register offsets, field positions, reset values and counts of the serial port.
// Assumes byte addressing on a 32-bit Avalon-MM bus with word aligned registers.
`ifndef SPSP_CONSTS_SVH
`define SPSP_CONSTS_SVH

`define SPSP_OFS_STATUS    4'h0
`define SPSP_OFS_CTRL1     4'h4
`define SPSP_OFS_CTRL2     4'h8
`define SPSP_OFS_BUFFER    4'hC

`define SPSP_RST_WORD      16'h0000
`define SPSP_CTRL1_MASK    16'h1FFF
`define SPSP_CTRL2_MASK    16'hE002

`define SPSP_ST_ENABLE     15
`define SPSP_ST_HALT       13
`define SPSP_ST_OVERFLOW   6
`define SPSP_ST_TX_FULL    1
`define SPSP_ST_RX_FULL    0

`define SPSP_C1_CLK_OFF    12
`define SPSP_C1_DOUT_OFF   11
`define SPSP_C1_WORD       10
`define SPSP_C1_PHASE      9
`define SPSP_C1_EDGE       8
`define SPSP_C1_SEL_EN     7
`define SPSP_C1_POL        6
`define SPSP_C1_MASTER     5
`define SPSP_C1_SEC_HI     4
`define SPSP_C1_SEC_LO     2
`define SPSP_C1_PRI_HI     1
`define SPSP_C1_PRI_LO     0

`define SPSP_C2_FRAMED     15
`define SPSP_C2_SYNC_DIR   14
`define SPSP_C2_SYNC_POL   13
`define SPSP_C2_SYNC_EDGE  1

`define SPSP_BYTE_LAST     5'd7
`define SPSP_WORD_LAST     5'd15
`define SPSP_SEC_BASE      12'd8
`define SPSP_PRI_TOP       2'd3

`endif

//--- hw/spsp_div_if.sv
// Carrier between the port core and its baud prescaler.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface spsp_div_if;
	logic       enable;
	logic [1:0] primary_divider;
	logic [2:0] secondary_divider;
	logic       tick;

	modport core (
		output enable,
		output primary_divider,
		output secondary_divider,
		input  tick
	);

	modport divider (
		input  enable,
		input  primary_divider,
		input  secondary_divider,
		output tick
	);
endinterface

//--- hw/spsp_pkg.sv
// Types shared by the serial port modules.
// Assumes the constants header is included by each module that needs numbers.
package spsp_pkg;

	typedef enum logic [1:0] {
		SPSP_IDLE  = 2'b00,
		SPSP_SYNC  = 2'b01,
		SPSP_SHIFT = 2'b10
	} spsp_state_t;

	typedef logic [15:0] spsp_word_t;

endpackage

//--- hw/spsp_port.sv
// Serial peripheral port core: registers on Avalon-MM, shift engine, pins.
// Assumes pins arrive asynchronously and the bus master is on clock.
//
// Overview of operation
// R1 - Shift register separate from software buffer.
// R2 - Master drives shift clock, slave receives it.
// R3 - Enable bit hands pins to the port.
// R4 - Halt-in-idle bit stops port in Idle.
// R5 - Unread buffer discards new data, sets overflow.
// R6 - Transmit and receive full flags track buffer.
// R7 - Word select picks 16 or 8 bits.
// R8 - Master samples at end or middle.
// R9 - Software keeps sample phase clear as slave.
// R10 - Edge bit picks which clock edge shifts.
// R11 - Framed mode ignores edge bit.
// R12 - Polarity bit picks idle clock level.
// R13 - Slave uses select pin only when enabled.
// R14 - Software keeps select enable clear when framed.
// R15 - Secondary prescale divides one to eight.
// R16 - Primary prescale divides 1, 4, 16, 64.
// R17 - Software never sets both prescalers to one.
// R18 - Framed mode uses select pin as sync.
// R19 - Sync direction picks input or output pulse.
// R20 - Sync polarity picks active high or low.
// R21 - Sync edge aligns pulse or leads bit.
// R22 - Disable bits return clock, data pins.
`timescale 1ns/1ps
`include "spsp_consts.svh"

module spsp_port
	import spsp_pkg::*;
(
	// System.
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        idle_mode,
	// Avalon-MM register slave.
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Shift clock pin.
	input  wire logic        shift_clock_pin_i,
	output logic             shift_clock_pin_o,
	output logic             shift_clock_pin_oe,
	// Data pins.
	input  wire logic        serial_in_pin_i,
	output logic             serial_out_pin_o,
	output logic             serial_out_pin_oe,
	// Select or frame sync pin.
	input  wire logic        select_pin_i,
	output logic             select_pin_o,
	output logic             select_pin_oe
);

	spsp_div_if div_if ();

	spsp_prescaler u_prescaler (
		.clock (clock),
		.rst   (rst),
		.div   (div_if.divider)
	);

	// Pin synchronisers: index 0 clock, 1 data in, 2 select.
	logic [2:0] pin_raw;
	logic [2:0] meta_q;
	logic [2:0] sync_q;

	assign pin_raw = {select_pin_i, serial_in_pin_i, shift_clock_pin_i};

	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				meta_q[i] <= 1'b0;
				sync_q[i] <= 1'b0;
			end else begin
				meta_q[i] <= pin_raw[i];
				sync_q[i] <= meta_q[i];
			end
		end
	end

	// Registers and engine state.
	spsp_state_t state_d, state_q;
	spsp_word_t  ctrl1_d, ctrl1_q;
	spsp_word_t  ctrl2_d, ctrl2_q;
	spsp_word_t  sr_d, sr_q;
	spsp_word_t  txb_d, txb_q;
	spsp_word_t  rxb_d, rxb_q;
	spsp_word_t  stat_word;
	logic        en_d, en_q;
	logic        halt_d, halt_q;
	logic        rov_d, rov_q;
	logic        tbf_d, tbf_q;
	logic        rbf_d, rbf_q;
	logic        half_d, half_q;
	logic [4:0]  bitcnt_d, bitcnt_q;
	logic [4:0]  last;
	logic        dout_d, dout_q;
	logic        sck_d, sck_q;
	logic        fs_d, fs_q;
	logic        synced_d, synced_q;
	logic        sck_prev_q;
	logic        ack_d, ack_q;
	logic [31:0] rdata_d, rdata_q;

	// Decoded controls.
	logic master, word, phase, cke_eff, sel_en, cpol;
	logic framed, sync_dir, sync_pol, sync_edge, run;
	logic fs_active, sck_rise, sck_fall, s_sample, s_change;
	logic sample_ev, change_ev, done, load;
	logic acc, acc_rd, acc_wr, buf_read;

	always_comb begin
		master    = ctrl1_q[`SPSP_C1_MASTER];
		word      = ctrl1_q[`SPSP_C1_WORD];
		phase     = ctrl1_q[`SPSP_C1_PHASE];
		sel_en    = ctrl1_q[`SPSP_C1_SEL_EN];
		cpol      = ctrl1_q[`SPSP_C1_POL];
		framed    = ctrl2_q[`SPSP_C2_FRAMED];
		sync_dir  = ctrl2_q[`SPSP_C2_SYNC_DIR];
		sync_pol  = ctrl2_q[`SPSP_C2_SYNC_POL];
		sync_edge = ctrl2_q[`SPSP_C2_SYNC_EDGE];
		cke_eff   = ctrl1_q[`SPSP_C1_EDGE] && !framed; // R11
		last      = word ? `SPSP_WORD_LAST : `SPSP_BYTE_LAST; // R7
		run       = en_q && !(halt_q && idle_mode); // R4
		fs_active = (sync_q[2] == sync_pol); // R20
		sck_rise  = sync_q[0] && !sck_prev_q;
		sck_fall  = !sync_q[0] && sck_prev_q;
		// Idle-to-active edge shifts out when the edge bit is clear.
		s_sample  = cke_eff ? (cpol ? sck_fall : sck_rise)
		                    : (cpol ? sck_rise : sck_fall); // R10
		s_change  = cke_eff ? (cpol ? sck_rise : sck_fall)
		                    : (cpol ? sck_fall : sck_rise); // R10
	end

	// Avalon-MM: one wait state, so read data come from a register.
	always_comb begin
		acc      = avs_read || avs_write;
		avs_waitrequest = acc && !ack_q;
		ack_d    = acc && !ack_q;
		acc_rd   = avs_read && ack_q;
		acc_wr   = avs_write && ack_q;
		buf_read = acc_rd && (avs_address == `SPSP_OFS_BUFFER);
		stat_word = `SPSP_RST_WORD;
		stat_word[`SPSP_ST_ENABLE]   = en_q;
		stat_word[`SPSP_ST_HALT]     = halt_q;
		stat_word[`SPSP_ST_OVERFLOW] = rov_q;
		stat_word[`SPSP_ST_TX_FULL]  = tbf_q;
		stat_word[`SPSP_ST_RX_FULL]  = rbf_q;
		rdata_d = rdata_q;
		if (avs_read && !ack_q) begin
			unique case (avs_address)
				`SPSP_OFS_STATUS: rdata_d = {16'h0000, stat_word};
				`SPSP_OFS_CTRL1:  rdata_d = {16'h0000, ctrl1_q};
				`SPSP_OFS_CTRL2:  rdata_d = {16'h0000, ctrl2_q};
				`SPSP_OFS_BUFFER: rdata_d = {16'h0000, rxb_q}; // R1
				default:          rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Shift engine.
	always_comb begin
		state_d   = state_q;
		half_d    = half_q;
		bitcnt_d  = bitcnt_q;
		sr_d      = sr_q;
		dout_d    = dout_q;
		synced_d  = synced_q;
		sample_ev = 1'b0;
		change_ev = 1'b0;
		done      = 1'b0;
		load      = 1'b0;
		if (!en_q) begin
			state_d  = SPSP_IDLE;
			half_d   = 1'b0;
			bitcnt_d = 5'd0;
			synced_d = 1'b0;
		end else if (run && master) begin
			unique case (state_q)
				SPSP_IDLE: begin
					// A sync input master waits for the partner's pulse.
					if (tbf_q && (!framed || !sync_dir || fs_active)) begin // R19
						load     = 1'b1;
						half_d   = 1'b0;
						bitcnt_d = 5'd0;
						state_d  = (framed && !sync_dir && !sync_edge)
						           ? SPSP_SYNC : SPSP_SHIFT; // R21
					end
				end
				SPSP_SYNC: begin
					if (div_if.tick) begin
						half_d = !half_q;
						if (half_q) begin
							state_d = SPSP_SHIFT;
						end
					end
				end
				SPSP_SHIFT: begin
					if (div_if.tick) begin
						half_d = !half_q;
						if (!half_q) begin
							sample_ev = !phase; // R8
						end else begin
							sample_ev = phase; // R8
							if (bitcnt_q == last) begin
								done    = 1'b1;
								state_d = SPSP_IDLE;
							end else begin
								change_ev = 1'b1;
								bitcnt_d  = bitcnt_q + 5'd1;
							end
						end
					end
				end
				default: state_d = SPSP_IDLE;
			endcase
		end else if (run) begin
			if (framed && fs_active) begin
				synced_d = 1'b1; // R18
			end
			if (!framed && sel_en && sync_q[2]) begin
				bitcnt_d = 5'd0; // R13
			end else if (!framed || synced_q) begin
				sample_ev = s_sample;
				change_ev = s_change && (bitcnt_q != 5'd0);
				if (s_sample) begin
					if (bitcnt_q == last) begin
						done     = 1'b1;
						bitcnt_d = 5'd0;
						synced_d = 1'b0;
					end else begin
						bitcnt_d = bitcnt_q + 5'd1;
					end
				end
			end
			if (bitcnt_q == 5'd0 && tbf_q && !s_sample && !s_change) begin
				load = 1'b1;
			end
		end
		if (sample_ev) begin
			sr_d = {sr_q[14:0], sync_q[1]}; // R1
		end
		if (change_ev) begin
			dout_d = word ? sr_d[15] : sr_d[7];
		end
		if (load) begin
			sr_d   = txb_q; // R1
			dout_d = word ? txb_q[15] : txb_q[7];
		end
		// Shift clock level follows the half bit, idle level otherwise.
		if (master && state_d != SPSP_IDLE) begin
			sck_d = cpol ^ (cke_eff ? half_d : !half_d); // R12
		end else begin
			sck_d = cpol; // R12
		end
		fs_d = master && framed && !sync_dir
		       && (state_d == SPSP_SYNC
		           || (state_d == SPSP_SHIFT && bitcnt_d == 5'd0
		               && sync_edge)); // R19 R21
	end

	// Register file and flags.
	always_comb begin
		en_d    = en_q;
		halt_d  = halt_q;
		ctrl1_d = ctrl1_q;
		ctrl2_d = ctrl2_q;
		rov_d   = rov_q;
		tbf_d   = tbf_q;
		rbf_d   = rbf_q;
		txb_d   = txb_q;
		rxb_d   = rxb_q;
		if (acc_wr) begin
			unique case (avs_address)
				`SPSP_OFS_STATUS: begin
					en_d   = avs_writedata[`SPSP_ST_ENABLE];
					halt_d = avs_writedata[`SPSP_ST_HALT];
					if (!avs_writedata[`SPSP_ST_OVERFLOW]) begin
						rov_d = 1'b0;
					end
				end
				`SPSP_OFS_CTRL1: ctrl1_d = avs_writedata[15:0] & `SPSP_CTRL1_MASK;
				`SPSP_OFS_CTRL2: ctrl2_d = avs_writedata[15:0] & `SPSP_CTRL2_MASK;
				`SPSP_OFS_BUFFER: begin
					txb_d = avs_writedata[15:0];
					tbf_d = 1'b1; // R6
				end
				default: ;
			endcase
		end
		if (buf_read) begin
			rbf_d = 1'b0; // R6
		end
		// A write in the same cycle as a load keeps the new value pending.
		if (load && !(acc_wr && avs_address == `SPSP_OFS_BUFFER)) begin
			tbf_d = 1'b0; // R6
		end
		if (done) begin
			if (rbf_q && !buf_read) begin
				rov_d = 1'b1; // R5
			end else begin
				rxb_d = word ? sr_d : {8'h00, sr_d[7:0]};
				rbf_d = 1'b1; // R6
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q    <= SPSP_IDLE;
			ctrl1_q    <= `SPSP_RST_WORD;
			ctrl2_q    <= `SPSP_RST_WORD;
			sr_q       <= `SPSP_RST_WORD;
			txb_q      <= `SPSP_RST_WORD;
			rxb_q      <= `SPSP_RST_WORD;
			en_q       <= 1'b0;
			halt_q     <= 1'b0;
			rov_q      <= 1'b0;
			tbf_q      <= 1'b0;
			rbf_q      <= 1'b0;
			half_q     <= 1'b0;
			bitcnt_q   <= 5'd0;
			dout_q     <= 1'b0;
			sck_q      <= 1'b0;
			fs_q       <= 1'b0;
			synced_q   <= 1'b0;
			sck_prev_q <= 1'b0;
			ack_q      <= 1'b0;
			rdata_q    <= 32'h0000_0000;
		end else begin
			state_q    <= state_d;
			ctrl1_q    <= ctrl1_d;
			ctrl2_q    <= ctrl2_d;
			sr_q       <= sr_d;
			txb_q      <= txb_d;
			rxb_q      <= rxb_d;
			en_q       <= en_d;
			halt_q     <= halt_d;
			rov_q      <= rov_d;
			tbf_q      <= tbf_d;
			rbf_q      <= rbf_d;
			half_q     <= half_d;
			bitcnt_q   <= bitcnt_d;
			dout_q     <= dout_d;
			sck_q      <= sck_d;
			fs_q       <= fs_d;
			synced_q   <= synced_d;
			sck_prev_q <= sync_q[0];
			ack_q      <= ack_d;
			rdata_q    <= rdata_d;
		end
	end

	// Prescaler runs only while a master frame is under way and not halted.
	// Holding it clear in idle makes the first half bit a full half bit.
	always_comb begin
		div_if.enable            = run && master
		                           && (state_q != SPSP_IDLE); // R15 R16
		div_if.primary_divider   =
			ctrl1_q[`SPSP_C1_PRI_HI:`SPSP_C1_PRI_LO]; // R16
		div_if.secondary_divider =
			ctrl1_q[`SPSP_C1_SEC_HI:`SPSP_C1_SEC_LO]; // R15
	end

	// Pins: with the port disabled every enable is low and the pins are GPIO.
	always_comb begin
		avs_readdata       = rdata_q;
		shift_clock_pin_o  = sck_q;
		shift_clock_pin_oe = en_q && master
		                     && !ctrl1_q[`SPSP_C1_CLK_OFF]; // R2 R3 R22
		serial_out_pin_o   = dout_q;
		serial_out_pin_oe  = en_q && !ctrl1_q[`SPSP_C1_DOUT_OFF]
		                     && (master || framed || !sel_en
		                         || !sync_q[2]); // R3 R13 R22
		select_pin_o       = fs_q ? sync_pol : !sync_pol; // R20
		select_pin_oe      = en_q && master && framed
		                     && !sync_dir; // R18 R19
	end

endmodule

//--- hw/spsp_prescaler.sv
// Two-stage baud prescaler for master mode: one tick per primary times
// secondary clocks. Assumes the core holds enable low when it is not a master.
`timescale 1ns/1ps
`include "spsp_consts.svh"

module spsp_prescaler
	import spsp_pkg::*;
(
	// System.
	input  wire logic       clock,
	input  wire logic       rst,
	// Core side.
	spsp_div_if.divider     div
);

	logic [11:0] pri_factor;
	logic [11:0] sec_factor;
	logic [11:0] limit;
	logic [11:0] count_d;
	logic [11:0] count_q;

	always_comb begin
		pri_factor = 12'h001 << {(`SPSP_PRI_TOP - div.primary_divider), 1'b0};
		sec_factor = `SPSP_SEC_BASE - {9'h000, div.secondary_divider};
		limit      = 12'(pri_factor * sec_factor) - 12'h001;
		div.tick   = div.enable && (count_q == limit);
		count_d    = (!div.enable || div.tick) ? 12'h000 : count_q + 12'h001;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count_q <= 12'h000;
		end else begin
			count_q <= count_d;
		end
	end

endmodule

//--- tb/spsp_far_end.sv
// Behavioural far-side peripheral: shifts a word out and one in, MSB first.
// Assumes the port is master; load starts a fresh frame.
`timescale 1ns/1ps

module spsp_far_end (
	// System.
	input wire logic        clock,
	// Serial lines.
	input wire logic        sck,
	input wire logic        mosi,
	output logic            miso,
	// Setup and result.
	input wire logic        pol,
	input wire logic        edge_sel,
	input wire logic        load,
	input wire logic [15:0] pattern,
	output logic     [15:0] rx
);
	logic        last_q;
	logic        first_q;
	logic [15:0] tx_q;

	assign miso = tx_q[15];

	// Bits past the word refill with the inverse so stale data never matches.
	always_ff @(posedge clock) begin
		last_q <= sck;
		if (load) begin
			tx_q <= pattern;
			rx <= 16'h0000;
			first_q <= !edge_sel;
		end else if (sck != last_q) begin
			if (sck == (edge_sel ? pol : !pol)) begin
				first_q <= 1'b0;
				if (!first_q)
					tx_q <= {tx_q[14:0], !tx_q[15]};
			end else
				rx <= {rx[14:0], mosi};
		end
	end
endmodule

//--- tb/spsp_props.sv
// Concurrent checks on the serial port bus and pin controls.
// Assumes control registers are only rewritten while the port is idle.
`timescale 1ns/1ps

module spsp_props (
	// System.
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        idle_mode,
	// Register bus.
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic        avs_waitrequest,
	// Pins.
	input wire logic        shift_clock_pin_o,
	input wire logic        shift_clock_pin_oe,
	input wire logic        serial_out_pin_o,
	input wire logic        serial_out_pin_oe,
	input wire logic        select_pin_oe
);
	logic        wr_acc;
	logic [15:0] st_q, st_d, c1_q, c1_d, c2_q, c2_d;
	logic        last_q;
	logic [9:0]  gap_q, gap_d;
	int          half;

	assign wr_acc = avs_write && !avs_waitrequest;

	// Shadow copies of the control bits, taken from accepted bus writes.
	always_comb begin
		st_d = st_q;
		c1_d = c1_q;
		c2_d = c2_q;
		if (wr_acc && avs_address == 4'h0)
			st_d = avs_writedata[15:0];
		if (wr_acc && avs_address == 4'h4)
			c1_d = avs_writedata[15:0];
		if (wr_acc && avs_address == 4'h8)
			c2_d = avs_writedata[15:0];
		gap_d = (gap_q == 10'h3FF) ? gap_q : gap_q + 10'h001;
		if (shift_clock_pin_o != last_q)
			gap_d = 10'h001;
		half = (1 << (6 - 2 * int'(c1_q[1:0]))) * (8 - int'(c1_q[4:2]));
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q <= 16'h0000;
			c1_q <= 16'h0000;
			c2_q <= 16'h0000;
			last_q <= 1'b0;
			gap_q <= 10'h3FF;
		end else begin
			st_q <= st_d;
			c1_q <= c1_d;
			c2_q <= c2_d;
			last_q <= shift_clock_pin_o;
			gap_q <= gap_d;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_wait_one;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence

	a_wait_one: assert property ($rose(avs_read || avs_write) |-> s_wait_one)
		else $error("bus wait state wrong");
	a_idle_nowait: assert property (
		!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait without request");
	a_clock_drive: assert property (
		shift_clock_pin_oe == (st_q[15] && c1_q[5] && !c1_q[12]))
		else $error("shift clock drive wrong");
	a_dout_drive: assert property (
		serial_out_pin_oe |-> st_q[15] && !c1_q[11])
		else $error("data out drive wrong");
	a_sync_drive: assert property (
		select_pin_oe == (st_q[15] && c1_q[5] && c2_q[15] && !c2_q[14]))
		else $error("sync drive wrong");
	a_idle_level: assert property (
		$rose(shift_clock_pin_oe) |=> shift_clock_pin_o == c1_q[6])
		else $error("idle clock level wrong");
	a_halt_freeze: assert property (
		idle_mode && st_q[13] && st_q[15] |=>
		$stable(shift_clock_pin_o) && $stable(serial_out_pin_o))
		else $error("halt did not freeze");
	a_half_period: assert property (
		st_q[15] && c1_q[5] && shift_clock_pin_o != last_q |->
		int'(gap_q) >= half)
		else $error("shift clock too fast");
endmodule

bind spsp_port spsp_props u_props (
	.clock(clock), .rst(rst), .idle_mode(idle_mode),
	.avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_waitrequest(avs_waitrequest),
	.shift_clock_pin_o(shift_clock_pin_o),
	.shift_clock_pin_oe(shift_clock_pin_oe),
	.serial_out_pin_o(serial_out_pin_o),
	.serial_out_pin_oe(serial_out_pin_oe),
	.select_pin_oe(select_pin_oe)
);

//--- tb/testbench.sv
// Self-checking bench for the serial port in master and slave setups.
// Assumes a far-side model on the pins and Avalon-MM register access.
`timescale 1ns/1ps

module testbench;
	logic        clock, rst, idle_mode, sel_n;
	logic [3:0]  avs_address;
	logic        avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata;
	logic        sck_o, sck_oe, sdo_o, sdo_oe, sel_o, sel_oe;
	logic        sck_w, sel_w, mosi, miso, pm_pol, pm_edge, pm_load;
	logic [15:0] pm_pat, pm_rx, rd;
	int          err_total, checks;

	// Pin levels resolved from every driver; data out idles high.
	assign sck_w = sck_oe ? sck_o : 1'b0;
	assign sel_w = sel_oe ? sel_o : sel_n;
	assign mosi = sdo_oe ? sdo_o : 1'b1;

	spsp_port uut (
		.clock(clock), .rst(rst), .idle_mode(idle_mode),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.shift_clock_pin_i(sck_w), .shift_clock_pin_o(sck_o),
		.shift_clock_pin_oe(sck_oe), .serial_in_pin_i(miso),
		.serial_out_pin_o(sdo_o), .serial_out_pin_oe(sdo_oe),
		.select_pin_i(sel_w), .select_pin_o(sel_o),
		.select_pin_oe(sel_oe)
	);

	spsp_far_end far (
		.clock(clock), .sck(sck_w), .mosi(mosi), .miso(miso),
		.pol(pm_pol), .edge_sel(pm_edge), .load(pm_load),
		.pattern(pm_pat), .rx(pm_rx)
	);

	task automatic end_sim;
		if (err_total == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic fail;
		err_total++;
		$display("Error timeout expected 1 seen 0");
		end_sim;
	endtask

	task automatic cmp(input string nm, input logic [15:0] e, g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {16'h0000, d};
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata[15:0];
		n = (avs_waitrequest === 1'b0) ? 0 : 1;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
		if (n != 0)
			fail();
	endtask

	task automatic wait_bit(input int b);
		int n;
		n = 0;
		do begin
			bus(1'b0, 4'h0, 16'h0000);
			n++;
		end while (rd[b] !== 1'b1 && n < 300);
		if (rd[b] !== 1'b1)
			fail();
	endtask

	task automatic pload(input logic [15:0] p, input logic pol, e);
		pm_pat <= p;
		pm_pol <= pol;
		pm_edge <= e;
		pm_load <= 1'b1;
		@(posedge clock);
		pm_load <= 1'b0;
	endtask

	task automatic t_regs;
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, 4'(i * 4), 16'h0000);
			cmp("reset_value", 16'h0000, rd);
		end
		bus(1'b1, 4'h2, 16'hFFFF);
		bus(1'b0, 4'h2, 16'h0000);
		cmp("unmapped", 16'h0000, rd);
		bus(1'b1, 4'h4, 16'hFFFF);
		bus(1'b0, 4'h4, 16'h0000);
		cmp("ctrl1", 16'h1FFF, rd);
		bus(1'b1, 4'h8, 16'hFFFF);
		bus(1'b0, 4'h8, 16'h0000);
		cmp("ctrl2", 16'hE002, rd);
		bus(1'b1, 4'h8, 16'h0000);
		bus(1'b1, 4'h4, 16'h0080);
		bus(1'b1, 4'h0, 16'h8000);
		repeat (4) @(posedge clock);
		cmp("slave_sck_oe", 16'h0000, {15'h0000, sck_oe});
		cmp("deselected_oe", 16'h0000, {15'h0000, sdo_oe});
		sel_n <= 1'b0;
		repeat (4) @(posedge clock);
		cmp("selected_oe", 16'h0001, {15'h0000, sdo_oe});
		bus(1'b1, 4'h0, 16'h0000);
		cmp("disabled_oe", 16'h0000, {15'h0000, sdo_oe});
		bus(1'b1, 4'h4, 16'h1820);
		bus(1'b1, 4'h0, 16'h8000);
		cmp("clk_off_oe", 16'h0000, {15'h0000, sck_oe});
		cmp("dout_off_oe", 16'h0000, {15'h0000, sdo_oe});
		bus(1'b1, 4'h4, 16'h0020);
		cmp("master_sck_oe", 16'h0001, {15'h0000, sck_oe});
		cmp("master_sdo_oe", 16'h0001, {15'h0000, sdo_oe});
		bus(1'b1, 4'h0, 16'h0000);
	endtask

	task automatic t_byte_halt;
		pload(16'hA500, 1'b0, 1'b0);
		bus(1'b1, 4'h4, 16'h0033);
		idle_mode <= 1'b1;
		bus(1'b1, 4'h0, 16'hA000);
		bus(1'b1, 4'hC, 16'h003C);
		bus(1'b0, 4'h0, 16'h0000);
		cmp("halted_status", 16'hA002, rd);
		idle_mode <= 1'b0;
		// Halt again in mid byte so the freeze is seen with the clock running.
		repeat (12) @(posedge clock);
		idle_mode <= 1'b1;
		repeat (20) @(posedge clock);
		idle_mode <= 1'b0;
		wait_bit(0);
		bus(1'b0, 4'hC, 16'h0000);
		cmp("byte_rx", 16'h00A5, rd);
		cmp("far_rx", 16'h003C, pm_rx);
		bus(1'b0, 4'h0, 16'h0000);
		cmp("after_read", 16'hA000, rd);
	endtask

	task automatic t_word_ovf;
		bus(1'b1, 4'h0, 16'h0000);
		bus(1'b1, 4'h4, 16'h077A);
		// The clock pin rises to its idle level on enable; load after that.
		bus(1'b1, 4'h0, 16'h8000);
		pload(16'hC3A5, 1'b1, 1'b1);
		bus(1'b1, 4'hC, 16'h9E6B);
		wait_bit(0);
		pload(16'h1234, 1'b1, 1'b1);
		bus(1'b1, 4'hC, 16'h0F0F);
		wait_bit(6);
		bus(1'b0, 4'hC, 16'h0000);
		cmp("kept_word", 16'hC3A5, rd);
		cmp("far_rx", 16'h0F0F, pm_rx);
		bus(1'b1, 4'h0, 16'h8000);
		bus(1'b0, 4'h0, 16'h0000);
		cmp("ovf_cleared", 16'h8000, rd);
	endtask

	task automatic t_framed;
		int n;
		bus(1'b1, 4'h0, 16'h0000);
		bus(1'b1, 4'h4, 16'h0023);
		bus(1'b1, 4'h8, 16'hA000);
		bus(1'b1, 4'h0, 16'h8000);
		cmp("sync_idle", 16'h0000, {15'h0000, sel_o});
		cmp("sync_oe", 16'h0001, {15'h0000, sel_oe});
		bus(1'b1, 4'hC, 16'h0081);
		n = 0;
		while (sel_o !== 1'b1 && n < 200) begin
			@(posedge clock);
			n++;
		end
		if (sel_o !== 1'b1)
			fail();
		cmp("sync_pulse", 16'h0001, {15'h0000, sel_o});
		// The sync bit clock runs ahead of bit 0; load the far end inside it.
		cmp("sync_leads", 16'h0001, {15'h0000, sck_o});
		pload(16'h5A00, 1'b0, 1'b0);
		wait_bit(0);
		bus(1'b0, 4'hC, 16'h0000);
		cmp("framed_rx", 16'h005A, rd);
		cmp("framed_far", 16'h0081, {8'h00, pm_rx[7:0]});
	endtask

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	initial begin
		err_total = 0;
		checks = 0;
		rst = 1'b1;
		idle_mode = 1'b0;
		sel_n = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		pm_pol = 1'b0;
		pm_edge = 1'b0;
		pm_load = 1'b0;
		pm_pat = 16'h0000;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_regs;
		t_byte_halt;
		t_word_ovf;
		t_framed;
		end_sim;
	end
endmodule
